//--- pkg/cmpc_defines.svh
// Register map, field positions, reset values and input select codes
`ifndef CMPC_DEFINES_SVH
`define CMPC_DEFINES_SVH

`define CMPC_CTRL_ADDR       8'h9b
`define CMPC_MODE_ADDR       8'h9d
`define CMPC_MUX_ADDR        8'h9f

`define CMPC_CTRL_RESET      8'h00
`define CMPC_MODE_RESET      8'h02
`define CMPC_MUX_RESET       8'hff

`define CMPC_CTRL_EN_BIT     7
`define CMPC_CTRL_RES_BIT    6
`define CMPC_CTRL_RISE_BIT   5
`define CMPC_CTRL_FALL_BIT   4
`define CMPC_CTRL_HYP_HI     3
`define CMPC_CTRL_HYP_LO     2
`define CMPC_CTRL_HYN_HI     1
`define CMPC_CTRL_HYN_LO     0

`define CMPC_MODE_RIE_BIT    5
`define CMPC_MODE_FIE_BIT    4
`define CMPC_MODE_MD_HI      1
`define CMPC_MODE_MD_LO      0

`define CMPC_MUX_NEG_HI      7
`define CMPC_MUX_NEG_LO      4
`define CMPC_MUX_POS_HI      3
`define CMPC_MUX_POS_LO      0

`define CMPC_SEL_LAST_PIN    4'h9
`define CMPC_NUM_PINS        10

`endif

//--- pkg/cmpc_pkg.sv
// Types shared by the comparator control logic
package cmpc_pkg;
	typedef logic [1:0] cmpc_hyst_t;
	typedef enum logic [1:0] {
		CMPC_MODE_FAST = 2'h0,
		CMPC_MODE_1    = 2'h1,
		CMPC_MODE_2    = 2'h2,
		CMPC_MODE_SLOW = 2'h3
	} cmpc_resp_t;
	typedef logic [3:0] cmpc_sel_t;
endpackage

//--- rtl/cmpc_core.sv
// Comparator control and status logic with its special function registers
// Overview of operation
// [R1] Comparator powered and operating only while enable bit 7 of control is set.
// [R2] Disabled comparator drives routed outputs low and has its supply removed.
// [R3] Control bit 6 reads the current result, high when positive exceeds negative.
// [R4] Falling transition of comparator output sets fall flag, control bit 4.
// [R5] Rising transition of comparator output sets rise flag, control bit 5.
// [R6] Edge flags stay set until software writes zero; hardware never clears them.
// [R7] Rising edge requests interrupt only while mode bit 5 enable is set.
// [R8] Falling edge requests interrupt only while mode bit 4 enable is set.
// [R9] Positive hysteresis in control bits 3:2 passed to analog core.
// [R10] Negative hysteresis in control bits 1:0 passed to analog core.
// [R11] Response mode in mode bits 1:0; 00 fastest, 11 slowest.
// [R12] Input select bits 7:4 choose negative pin; codes 1010-1111 connect none.
// [R13] Input select bits 3:0 choose positive pin; codes 1010-1111 connect none.
// [R14] Two outputs: one clocked, one raw valid without the clock.
// [R15] Software should clear edge flags after enabling or changing mode settings.
// [R16] Comparator output offered as reset request and channel shutoff trigger.
// [R17] Mode bits 7:6 and 3:2 read zero and ignore writes.
// [R18] Raw output passes two synchroniser flops before edge detection and status.
`include "cmpc_defines.svh"

module cmpc_core #(
	parameter int NUM_PINS = `CMPC_NUM_PINS
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            sfr_addr,
	input  wire logic                  sfr_wr,
	input  wire logic                  sfr_rd,
	input  wire logic [7:0]            sfr_wdata,
	output logic      [7:0]            sfr_rdata,
	input  wire logic                  ana_cmp_in,
	output logic                       ana_power_en,
	output logic                       ana_enable,
	output cmpc_pkg::cmpc_hyst_t       pos_hyst_sel,
	output cmpc_pkg::cmpc_hyst_t       neg_hyst_sel,
	output cmpc_pkg::cmpc_resp_t       response_mode,
	output cmpc_pkg::cmpc_sel_t        pos_input_sel,
	output cmpc_pkg::cmpc_sel_t        neg_input_sel,
	output logic [NUM_PINS-1:0]        pos_pin_connect,
	output logic [NUM_PINS-1:0]        neg_pin_connect,
	output logic                       cmp_raw_out,
	output logic                       cmp_sync_out,
	output logic                       cmp_irq_req,
	output logic                       cmp_reset_src,
	output logic                       cmp_kill_trig
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic                       enable_reg;
	logic                       rise_flag_reg;
	logic                       fall_flag_reg;
	cmpc_pkg::cmpc_hyst_t       pos_hyst_reg;
	cmpc_pkg::cmpc_hyst_t       neg_hyst_reg;
	logic                       rise_irq_en_reg;
	logic                       fall_irq_en_reg;
	cmpc_pkg::cmpc_resp_t       mode_reg;
	cmpc_pkg::cmpc_sel_t        neg_sel_reg;
	cmpc_pkg::cmpc_sel_t        pos_sel_reg;
	logic                       sync1_reg;
	logic                       sync2_reg;
	logic                       prev_reg;
	logic                       out_reg;
	logic [7:0]                 rdata_reg;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [7:0] CTRL_RST = `CMPC_CTRL_RESET;
	localparam logic [7:0] MODE_RST = `CMPC_MODE_RESET;
	localparam logic [7:0] MUX_RST  = `CMPC_MUX_RESET;

	// ************************************************************
	// Decode
	// ************************************************************
	wire logic       hit_ctrl   = sfr_addr == `CMPC_CTRL_ADDR;
	wire logic       hit_mode   = sfr_addr == `CMPC_MODE_ADDR;
	wire logic       hit_mux    = sfr_addr == `CMPC_MUX_ADDR;
	wire logic       wr_ctrl    = sfr_wr & hit_ctrl;
	wire logic       wr_mode    = sfr_wr & hit_mode;
	wire logic       wr_mux     = sfr_wr & hit_mux;
	// [R18] Result gated by enable after the synchroniser
	wire logic       cmp_level  = sync2_reg & enable_reg;
	// [R4] [R5] Edges of the synchronised result
	wire logic       rise_evt   = cmp_level & ~prev_reg;
	wire logic       fall_evt   = ~cmp_level & prev_reg;
	// [R6] Set wins over a software clear
	wire logic       rise_next  = rise_evt |
		(wr_ctrl ? sfr_wdata[`CMPC_CTRL_RISE_BIT] : rise_flag_reg);
	wire logic       fall_next  = fall_evt |
		(wr_ctrl ? sfr_wdata[`CMPC_CTRL_FALL_BIT] : fall_flag_reg);

	wire logic [7:0] ctrl_view  = {enable_reg, out_reg, rise_flag_reg, fall_flag_reg,
		pos_hyst_reg, neg_hyst_reg};
	// [R17] Unused mode bits read zero
	wire logic [7:0] mode_view  = {2'h0, rise_irq_en_reg, fall_irq_en_reg, 2'h0, mode_reg};
	wire logic [7:0] mux_view   = {neg_sel_reg, pos_sel_reg};
	wire logic [7:0] rd_mux     = hit_ctrl ? ctrl_view :
		hit_mode ? mode_view :
		hit_mux ? mux_view : 8'h00;

	// ************************************************************
	// Control registers
	// ************************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_reg   <= CTRL_RST[`CMPC_CTRL_EN_BIT];
			pos_hyst_reg <= CTRL_RST[`CMPC_CTRL_HYP_HI:`CMPC_CTRL_HYP_LO];
			neg_hyst_reg <= CTRL_RST[`CMPC_CTRL_HYN_HI:`CMPC_CTRL_HYN_LO];
		end else if (wr_ctrl) begin
			// [R1] Enable bit
			enable_reg   <= sfr_wdata[`CMPC_CTRL_EN_BIT];
			// [R9] [R10] Hysteresis fields
			pos_hyst_reg <= sfr_wdata[`CMPC_CTRL_HYP_HI:`CMPC_CTRL_HYP_LO];
			neg_hyst_reg <= sfr_wdata[`CMPC_CTRL_HYN_HI:`CMPC_CTRL_HYN_LO];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rise_flag_reg <= CTRL_RST[`CMPC_CTRL_RISE_BIT];
			fall_flag_reg <= CTRL_RST[`CMPC_CTRL_FALL_BIT];
		end else begin
			// [R4] [R5] [R6] Sticky edge flags
			rise_flag_reg <= rise_next;
			fall_flag_reg <= fall_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rise_irq_en_reg <= MODE_RST[`CMPC_MODE_RIE_BIT];
			fall_irq_en_reg <= MODE_RST[`CMPC_MODE_FIE_BIT];
			mode_reg        <= cmpc_pkg::cmpc_resp_t'(MODE_RST[`CMPC_MODE_MD_HI:`CMPC_MODE_MD_LO]);
		end else if (wr_mode) begin
			// [R17] Only used bits stored
			rise_irq_en_reg <= sfr_wdata[`CMPC_MODE_RIE_BIT];
			fall_irq_en_reg <= sfr_wdata[`CMPC_MODE_FIE_BIT];
			// [R11] Response mode
			mode_reg <= cmpc_pkg::cmpc_resp_t'(sfr_wdata[`CMPC_MODE_MD_HI:`CMPC_MODE_MD_LO]);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			neg_sel_reg <= MUX_RST[`CMPC_MUX_NEG_HI:`CMPC_MUX_NEG_LO];
			pos_sel_reg <= MUX_RST[`CMPC_MUX_POS_HI:`CMPC_MUX_POS_LO];
		end else if (wr_mux) begin
			// [R12] [R13] Input selects
			neg_sel_reg <= sfr_wdata[`CMPC_MUX_NEG_HI:`CMPC_MUX_NEG_LO];
			pos_sel_reg <= sfr_wdata[`CMPC_MUX_POS_HI:`CMPC_MUX_POS_LO];
		end
	end

	// ************************************************************
	// Synchroniser and edge history
	// ************************************************************
	// [R18] Two flops, first read only by second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			prev_reg  <= 1'b0;
			out_reg   <= 1'b0;
		end else begin
			sync1_reg <= ana_cmp_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= cmp_level;
			// [R3] Latched result for status and clocked output
			out_reg   <= cmp_level;
		end
	end

	// Read data held until the next read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (sfr_rd) begin
			rdata_reg <= rd_mux;
		end
	end
	assign sfr_rdata = rdata_reg;

	// ************************************************************
	// Outputs
	// ************************************************************
	// [R1] [R2] Power and operation follow enable
	assign ana_power_en  = enable_reg;
	assign ana_enable    = enable_reg;
	assign pos_hyst_sel  = pos_hyst_reg;
	assign neg_hyst_sel  = neg_hyst_reg;
	assign response_mode = mode_reg;
	assign pos_input_sel = pos_sel_reg;
	assign neg_input_sel = neg_sel_reg;

	// [R12] [R13] One-hot pin connects; high codes select none
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			assign pos_pin_connect[gi] = enable_reg && (pos_sel_reg == 4'(gi));
			assign neg_pin_connect[gi] = enable_reg && (neg_sel_reg == 4'(gi));
		end
	endgenerate

	// [R2] [R14] Raw output gated low while disabled
	assign cmp_raw_out   = ana_cmp_in & enable_reg;
	assign cmp_sync_out  = out_reg & enable_reg;
	// [R7] [R8] Masked interrupt request
	assign cmp_irq_req   = (rise_flag_reg & rise_irq_en_reg) | (fall_flag_reg & fall_irq_en_reg);
	// [R16] Reset source and channel shutoff trigger
	assign cmp_reset_src = cmp_sync_out;
	assign cmp_kill_trig = cmp_sync_out;

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_rise_set;
		@(posedge clk) disable iff (rst) rise_evt |=> rise_flag_reg;
	endproperty
	a_rise_set: assert property (p_rise_set) else $error("rise flag not set"); // [R5]

	property p_fall_set;
		@(posedge clk) disable iff (rst) fall_evt |=> fall_flag_reg;
	endproperty
	a_fall_set: assert property (p_fall_set) else $error("fall flag not set"); // [R4]

	property p_sticky;
		@(posedge clk) disable iff (rst) rise_flag_reg && !wr_ctrl |=> rise_flag_reg;
	endproperty
	a_sticky: assert property (p_sticky) else $error("rise flag cleared by hardware"); // [R6]

	sequence s_in_high;
		ana_cmp_in && enable_reg;
	endsequence
	property p_sync_lat;
		@(posedge clk) disable iff (rst) s_in_high ##1 s_in_high ##1 s_in_high |=> out_reg;
	endproperty
	a_sync_lat: assert property (p_sync_lat) else $error("latched result lags"); // [R18]

	property p_disabled_low;
		@(posedge clk) disable iff (rst) !enable_reg |-> !cmp_raw_out && !cmp_sync_out;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("output high when off"); // [R2]

	property p_irq_rise;
		@(posedge clk) disable iff (rst) rise_flag_reg && rise_irq_en_reg |-> cmp_irq_req;
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("rise interrupt missing"); // [R7]

	property p_irq_fall;
		@(posedge clk) disable iff (rst) fall_flag_reg && fall_irq_en_reg |-> cmp_irq_req;
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("fall interrupt missing"); // [R8]

	property p_mode_zero;
		@(posedge clk) disable iff (rst) sfr_rd && hit_mode |=> (sfr_rdata & 8'hcc) == 8'h00;
	endproperty
	a_mode_zero: assert property (p_mode_zero) else $error("unused mode bits nonzero"); // [R17]

	property p_status;
		@(posedge clk) disable iff (rst) sfr_rd && hit_ctrl |=> sfr_rdata[6] == $past(out_reg);
	endproperty
	a_status: assert property (p_status) else $error("status bit mismatch"); // [R3]

	property p_power;
		@(posedge clk) disable iff (rst) wr_ctrl |=> ana_power_en == $past(sfr_wdata[7]);
	endproperty
	a_power: assert property (p_power) else $error("power not following enable"); // [R1]

	property p_fall_sticky;
		@(posedge clk) disable iff (rst) fall_flag_reg && !wr_ctrl |=> fall_flag_reg;
	endproperty
	a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag lost"); // [R6]

	property p_mask_rise;
		@(posedge clk) disable iff (rst)
			!rise_irq_en_reg && !(fall_flag_reg && fall_irq_en_reg) |-> !cmp_irq_req;
	endproperty
	a_mask_rise: assert property (p_mask_rise) else $error("rise not masked"); // [R7]

	property p_mask_fall;
		@(posedge clk) disable iff (rst)
			!fall_irq_en_reg && !(rise_flag_reg && rise_irq_en_reg) |-> !cmp_irq_req;
	endproperty
	a_mask_fall: assert property (p_mask_fall) else $error("fall not masked"); // [R8]

	property p_hyst_pos;
		@(posedge clk) disable iff (rst)
			wr_ctrl |=> pos_hyst_sel == $past(sfr_wdata[`CMPC_CTRL_HYP_HI:`CMPC_CTRL_HYP_LO]);
	endproperty
	a_hyst_pos: assert property (p_hyst_pos) else $error("positive hysteresis lost"); // [R9]

	property p_hyst_neg;
		@(posedge clk) disable iff (rst)
			wr_ctrl |=> neg_hyst_sel == $past(sfr_wdata[`CMPC_CTRL_HYN_HI:`CMPC_CTRL_HYN_LO]);
	endproperty
	a_hyst_neg: assert property (p_hyst_neg) else $error("negative hysteresis lost"); // [R10]

	property p_resp;
		@(posedge clk) disable iff (rst)
			wr_mode |=> response_mode == $past(sfr_wdata[`CMPC_MODE_MD_HI:`CMPC_MODE_MD_LO]);
	endproperty
	a_resp: assert property (p_resp) else $error("response mode lost"); // [R11]

	property p_mux_wr;
		@(posedge clk) disable iff (rst)
			wr_mux |=> neg_input_sel == $past(sfr_wdata[`CMPC_MUX_NEG_HI:`CMPC_MUX_NEG_LO]) &&
				pos_input_sel == $past(sfr_wdata[`CMPC_MUX_POS_HI:`CMPC_MUX_POS_LO]);
	endproperty
	a_mux_wr: assert property (p_mux_wr) else $error("input select lost"); // [R12] [R13]

	property p_none_neg;
		@(posedge clk) disable iff (rst)
			neg_sel_reg > `CMPC_SEL_LAST_PIN |-> neg_pin_connect == '0;
	endproperty
	a_none_neg: assert property (p_none_neg) else $error("negative pin on high code"); // [R12]

	property p_none_pos;
		@(posedge clk) disable iff (rst)
			pos_sel_reg > `CMPC_SEL_LAST_PIN |-> pos_pin_connect == '0;
	endproperty
	a_none_pos: assert property (p_none_pos) else $error("positive pin on high code"); // [R13]

	property p_onehot;
		@(posedge clk) disable iff (rst)
			$onehot0(pos_pin_connect) && $onehot0(neg_pin_connect);
	endproperty
	a_onehot: assert property (p_onehot) else $error("several pins connected"); // [R13]

	property p_supply_off;
		@(posedge clk) disable iff (rst)
			!enable_reg |-> !ana_power_en && !ana_enable && pos_pin_connect == '0;
	endproperty
	a_supply_off: assert property (p_supply_off) else $error("supply on when off"); // [R2]

	property p_raw;
		@(posedge clk) disable iff (rst) enable_reg && ana_cmp_in |-> cmp_raw_out;
	endproperty
	a_raw: assert property (p_raw) else $error("raw output missing"); // [R14]

	property p_trigger;
		@(posedge clk) disable iff (rst) cmp_sync_out |-> cmp_reset_src && cmp_kill_trig;
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger outputs missing"); // [R16]

	sequence s_in_low;
		!ana_cmp_in && enable_reg;
	endsequence
	property p_rise_path;
		@(posedge clk) disable iff (rst) !ana_cmp_in ##1 s_in_high [*3] |=> rise_flag_reg;
	endproperty
	a_rise_path: assert property (p_rise_path) else $error("rise not flagged"); // [R5]

	property p_fall_path;
		@(posedge clk) disable iff (rst) s_in_high ##1 s_in_low [*3] |=> fall_flag_reg;
	endproperty
	a_fall_path: assert property (p_fall_path) else $error("fall not flagged"); // [R4]

	property p_sync_low;
		@(posedge clk) disable iff (rst) s_in_low [*3] |=> !out_reg;
	endproperty
	a_sync_low: assert property (p_sync_low) else $error("latched result stuck"); // [R18]

endmodule

//--- sim/cmpc_ana_model.sv
// Behavioural analog comparator core fed by per-pin voltages
module cmpc_ana_model (
	input  wire logic            ana_power_en,
	input  wire logic [9:0]      pos_pin_connect,
	input  wire logic [9:0]      neg_pin_connect,
	input  wire logic [9:0][7:0] pos_mv,
	input  wire logic [9:0][7:0] neg_mv,
	output logic                 ana_cmp_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] vp;
	logic [7:0] vn;
	// Selected pin voltages
	always_comb begin
		vp = 8'h00;
		vn = 8'hff;
		for (int i = 0; i < 10; i++) begin
			if (pos_pin_connect[i])
				vp = pos_mv[i];
			if (neg_pin_connect[i])
				vn = neg_mv[i];
		end
	end
	// Unpowered core reads low
	assign ana_cmp_in = ana_power_en & (vp > vn);
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the comparator control logic
`include "cmpc_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 clk, rst, sfr_wr, sfr_rd, ana_cmp_in, ana_power_en, ana_enable;
	logic                 cmp_raw_out, cmp_sync_out, cmp_irq_req, cmp_reset_src, cmp_kill_trig;
	logic [7:0]           sfr_addr, sfr_wdata, sfr_rdata, rdv;
	cmpc_pkg::cmpc_hyst_t pos_hyst_sel, neg_hyst_sel;
	cmpc_pkg::cmpc_resp_t response_mode;
	cmpc_pkg::cmpc_sel_t  pos_input_sel, neg_input_sel;
	logic [9:0]           pos_pin_connect, neg_pin_connect;
	logic [9:0][7:0]      pos_mv;
	logic [9:0][7:0]      neg_mv;
	int                   fails, checks;

	cmpc_core DUT (.clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
		.ana_cmp_in, .ana_power_en, .ana_enable, .pos_hyst_sel, .neg_hyst_sel,
		.response_mode, .pos_input_sel, .neg_input_sel, .pos_pin_connect,
		.neg_pin_connect, .cmp_raw_out, .cmp_sync_out, .cmp_irq_req,
		.cmp_reset_src, .cmp_kill_trig);
	cmpc_ana_model ana (.ana_power_en, .pos_pin_connect, .neg_pin_connect,
		.pos_mv, .neg_mv, .ana_cmp_in);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(negedge clk);
		sfr_rd = 1'b0;
		rdv = sfr_rdata;
	endtask

	task automatic wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic t_reset();
		rd(`CMPC_CTRL_ADDR);
		check(16'(rdv), 16'h00);
		check(16'({ana_power_en, pos_pin_connect}), 16'h000);
		rd(`CMPC_MODE_ADDR);
		check(16'(rdv), 16'h02);
		check(16'(response_mode), 16'h02);
		rd(`CMPC_MUX_ADDR);
		check(16'(rdv), 16'hff);
		check(16'({neg_input_sel, pos_input_sel}), 16'hff);
		$display("reset test done");
	endtask

	task automatic t_mode();
		wr(`CMPC_MODE_ADDR, 8'hff);
		rd(`CMPC_MODE_ADDR);
		check(16'(rdv), 16'h33);
		for (int m = 0; m < 4; m++) begin
			wr(`CMPC_MODE_ADDR, 8'(m));
			check(16'(response_mode), 16'(m));
		end
		$display("mode test done");
	endtask

	task automatic t_hyst();
		for (int h = 0; h < 4; h++) begin
			wr(`CMPC_CTRL_ADDR, 8'h40 | 8'(h * 4 + 3 - h));
			check(16'(pos_hyst_sel), 16'(h));
			check(16'(neg_hyst_sel), 16'(3 - h));
		end
		wr(8'h9c, 8'hff);
		rd(8'h9c);
		check(16'(rdv), 16'h00);
		rd(`CMPC_CTRL_ADDR);
		check(16'(rdv), 16'h0c);
		$display("hysteresis test done");
	endtask

	task automatic t_mux();
		wr(`CMPC_CTRL_ADDR, 8'h80);
		check(16'({ana_power_en, ana_enable}), 16'h3);
		for (int c = 0; c < 16; c++) begin
			wr(`CMPC_MUX_ADDR, 8'(c * 16 + 15 - c));
			check(16'(neg_pin_connect), c < 10 ? 16'(1) << c : 16'h0);
			check(16'(pos_pin_connect), c > 5 ? 16'(1) << (15 - c) : 16'h0);
		end
		wr(`CMPC_MUX_ADDR, 8'h00);
		repeat (3) @(negedge clk);
		$display("mux test done");
	endtask

	task automatic t_edges();
		wr(`CMPC_CTRL_ADDR, 8'h80);
		@(negedge clk);
		pos_mv[0] = 8'd90;
		#1 check(16'(cmp_raw_out), 16'h1);
		@(negedge clk);
		check(16'(cmp_sync_out), 16'h0);
		@(negedge clk);
		check(16'(cmp_sync_out), 16'h0);
		@(negedge clk);
		check(16'(cmp_sync_out), 16'h1);
		check(16'({cmp_reset_src, cmp_kill_trig}), 16'h3);
		check(16'(cmp_irq_req), 16'h0);
		rd(`CMPC_CTRL_ADDR);
		check(16'(rdv), 16'he0);
		wr(`CMPC_MODE_ADDR, 8'h20);
		check(16'(cmp_irq_req), 16'h1);
		pos_mv[0] = 8'd10;
		repeat (3) @(negedge clk);
		rd(`CMPC_CTRL_ADDR);
		check(16'(rdv), 16'hb0);
		wr(`CMPC_MODE_ADDR, 8'h10);
		check(16'(cmp_irq_req), 16'h1);
		wr(`CMPC_CTRL_ADDR, 8'ha0);
		check(16'(cmp_irq_req), 16'h0);
		rd(`CMPC_CTRL_ADDR);
		check(16'(rdv), 16'ha0);
		$display("edge test done");
	endtask

	task automatic t_disable();
		pos_mv[0] = 8'd90;
		repeat (3) @(negedge clk);
		check(16'(cmp_sync_out), 16'h1);
		wr(`CMPC_CTRL_ADDR, 8'h00);
		check(16'({ana_power_en, ana_enable, cmp_raw_out}), 16'h0);
		check(16'(pos_pin_connect), 16'h0);
		repeat (3) @(negedge clk);
		check(16'(cmp_sync_out), 16'h0);
		$display("disable test done");
	endtask

	initial begin
		rst = 1'b1;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
		pos_mv = {10{8'd10}};
		neg_mv = {10{8'd50}};
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_mode();
		t_hyst();
		t_mux();
		t_edges();
		t_disable();
		wrap_up();
	end

	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule
